// ==== omn_map.svh ====
// Register indices, field positions, reset values and constants of the monitor/oscillator block.
// Assumes a byte-addressed 32-bit bus; a register's byte address is four times its index.
`ifndef OMN_MAP_SVH
`define OMN_MAP_SVH

`define OMN_IDX_GAIN_A      12'h022
`define OMN_IDX_GAIN_B      12'h023
`define OMN_IDX_OFFSET_A    12'h025
`define OMN_IDX_OFFSET_B    12'h026
`define OMN_IDX_SRC_CFG     12'h20c
`define OMN_IDX_IDX_SEL     12'h20d
`define OMN_IDX_THR_HIGH    12'h030
`define OMN_IDX_THR_LOW     12'h031
`define OMN_IDX_PERIOD      12'h032
`define OMN_IDX_CTRL        12'h033
`define OMN_IDX_STATUS      12'h034
`define OMN_IDX_STEP_BASE   12'h100
`define OMN_IDX_PHASE_BASE  12'h110
`define OMN_IDX_PRESET_MASK 12'hff8

`define OMN_SRC_BIT         0
`define OMN_CTRL_PD_BIT     0
`define OMN_CTRL_BGCAL_BIT  1
`define OMN_STAT_FLAGH_BIT  0
`define OMN_STAT_FLAGL_BIT  1
`define OMN_STAT_IDX_LSB    2
`define OMN_STAT_PD_BIT     5

`define OMN_RST_BYTE        8'h00
`define OMN_RST_HALF        16'h0000
`define OMN_RST_WORD        32'h0000_0000
`define OMN_RST_IDX         3'h0
`define OMN_QUARTER_TURN    32'h4000_0000

`endif

// ==== omn_pkg.sv ====
// Types shared by the monitor/oscillator block.
// Assumes omn_map.svh supplies the numeric constants.
package omn_pkg;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } omn_iq_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
  } omn_analog_t;

endpackage : omn_pkg

// ==== omn_range_mon.sv ====
// Over-range monitor: magnitude of each raw sample, windowed compare against two thresholds.
// Assumes one offset-binary sample per clock while run is high.
module omn_range_mon #(
  parameter int SW = 12,
  parameter int TW = 8,
  parameter int PW = 3
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          run,
  input  wire logic [SW-1:0] sampleIn,
  input  wire logic [TW-1:0] thrHigh,
  input  wire logic [TW-1:0] thrLow,
  input  wire logic [PW-1:0] periodExp,
  output logic               flagHigh,
  output logic               flagLow
);
  localparam int CW = (1 << PW) - 1;

  logic [SW-1:0] signedS;
  logic [SW-2:0] mag;
  logic [TW-1:0] top;
  logic [CW:0]   span;
  logic [CW-1:0] mask;
  logic [CW-1:0] cnt_r;
  logic          accH_r;
  logic          accL_r;
  logic          hitH;
  logic          hitL;
  logic          winEnd;

  always_comb
  begin
    signedS = {~sampleIn[SW-1], sampleIn[SW-2:0]};
    if (!signedS[SW-1])
      mag = signedS[SW-2:0];
    else if (signedS[SW-2:0] == '0)
      mag = '1; // Most negative code saturates
    else
      mag = (SW-1)'(~signedS + 1'b1);
  end

  assign top    = mag[SW-2 -: TW];
  assign hitH   = top >= thrHigh;
  assign hitL   = top >= thrLow;
  assign span   = (CW+1)'(1) << periodExp;
  assign mask   = CW'(span - (CW+1)'(1));
  // Free-running count keeps windows aligned even if the period changes
  assign winEnd = (cnt_r & mask) == mask;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_r <= '0;
    else if (run)
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      accH_r   <= 1'b0;
      accL_r   <= 1'b0;
      flagHigh <= 1'b0;
      flagLow  <= 1'b0;
    end
    else if (run && winEnd)
    begin
      flagHigh <= accH_r | hitH;
      flagLow  <= accL_r | hitL;
      accH_r   <= 1'b0;
      accL_r   <= 1'b0;
    end
    else if (run)
    begin
      accH_r <= accH_r | hitH;
      accL_r <= accL_r | hitL;
    end
  end

endmodule : omn_range_mon

// ==== omn_nco_bank.sv ====
// Bank of free-running phase accumulators with preset select and phase offset.
// Assumes presets are stable register contents from the bus side.
module omn_nco_bank #(
  parameter int N   = 8,
  parameter int AW  = 32,
  parameter int PHW = 16,
  parameter int IW  = 3
) (
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire logic [AW-1:0]  stepPreset  [N],
  input  wire logic [PHW-1:0] phasePreset [N],
  input  wire logic [IW-1:0]  selIdx,
  output logic      [AW-1:0]  phaseOut
);
  logic [AW-1:0] acc_r [N];

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gAcc
      // Every accumulator advances regardless of selection
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          acc_r[g] <= '0;
        else
          acc_r[g] <= acc_r[g] + stepPreset[g]; // Wraps modulo 2**AW
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      phaseOut <= '0;
    else
      phaseOut <= acc_r[selIdx] + {phasePreset[selIdx], {(AW-PHW){1'b0}}};
  end

endmodule : omn_nco_bank

// ==== omn_top.sv ====
// Top of the monitor/oscillator block: Wishbone registers, preset select, mixer, output words.
// Assumes one offset-binary sample per sys_clk and a classic Wishbone master.
//
// Behaviour
// - Monitor every raw sample's magnitude; compare its top eight bits with two thresholds.
// - Offset binary to signed, 11-bit magnitude; most negative code saturates.
// - Flag is one if any magnitude in window meets its threshold.
// - High flag sits in LSB of each I word, under top 15 I bits.
// - Low flag sits in LSB of each Q word, under top 15 Q bits.
// - Window length is two to the power of the 3-bit period setting.
// - Full-scale gain comes from two adjacent registers and drives input range.
// - With background calibration on, the programmed offset has no effect.
// - Power-down bit set powers block down and disables serial output drivers.
// - Eight accumulators all advance every cycle, whichever is selected.
// - Source bit picks preset index from pins (0) or register field (1).
// - Each accumulator uses its own step and phase preset.
// - Accumulator adds its 32-bit step each clock, modulo two to the 32.
// - Real samples times selected complex exponential give I and Q products.
// - 16-bit phase preset left-justified to 32 bits, added before exponential.
//
// Local design decision: the Wishbone slave port.
`include "omn_map.svh"

module omn_top #(
  parameter int SW = 12,
  parameter int N  = 8
) (
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [13:0]    wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  input  wire logic [SW-1:0]  sampleIn,
  input  wire logic [2:0]     presetIndexPins,
  output omn_pkg::omn_iq_t    iqOut,
  output logic                iqValid,
  output omn_pkg::omn_analog_t analogOut,
  output logic                powerDown,
  output logic                serialDriveEn
);
  localparam int PW = 21;

  logic [7:0]  gainA_r;
  logic [7:0]  gainB_r;
  logic [7:0]  offA_r;
  logic [7:0]  offB_r;
  logic [7:0]  srcCfg_r;
  logic [7:0]  idxSel_r;
  logic [7:0]  thrHigh_r;
  logic [7:0]  thrLow_r;
  logic [7:0]  period_r;
  logic [7:0]  ctrl_r;
  logic [31:0] step_r  [N];
  logic [15:0] phase_r [N];

  logic [11:0] regIdx;
  logic        wbReq;
  logic        wbWrite;
  logic [31:0] readMux;
  logic [2:0]  curIdx_r;
  logic [SW-1:0] sample_r;
  logic [SW-1:0] sampleMix_r;
  logic [31:0] phaseSel;
  logic        flagHigh;
  logic        flagLow;
  logic signed [8:0]    cosV;
  logic signed [8:0]    sinV;
  logic signed [SW-1:0] sx;
  logic signed [PW-1:0] iProd;
  logic signed [PW-1:0] qProd;

  // Merge write data into an old value by byte lane
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction : laneMerge

  function automatic logic isPreset(input logic [11:0] idx, input logic [11:0] base);
    return (idx & `OMN_IDX_PRESET_MASK) == base;
  endfunction : isPreset

  // Coarse quarter-wave table; spurs traded for area at this stage
  function automatic logic signed [8:0] sineAt(input logic [31:0] ph);
    logic [3:0] k;
    logic [7:0] amp;
    // Falling quarter mirrors the rising one, so zero and peak land exactly
    k = ph[30] ? 4'h8 - {1'b0, ph[29:27]} : {1'b0, ph[29:27]};
    case (k)
      4'h0: amp = 8'h00;
      4'h1: amp = 8'h32;
      4'h2: amp = 8'h62;
      4'h3: amp = 8'h8e;
      4'h4: amp = 8'hb4;
      4'h5: amp = 8'hd4;
      4'h6: amp = 8'hec;
      4'h7: amp = 8'hfa;
      4'h8: amp = 8'hff;
      default: amp = 8'h00;
    endcase
    return ph[31] ? -$signed({1'b0, amp}) : $signed({1'b0, amp});
  endfunction : sineAt

  assign regIdx  = wb_adr_i[13:2];
  assign wbReq   = wb_cyc_i && wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign wbWrite = wbReq && wb_we_i && wb_ack_o;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wbReq && !wb_ack_o;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gainA_r <= `OMN_RST_BYTE;
      gainB_r <= `OMN_RST_BYTE;
      offA_r  <= `OMN_RST_BYTE;
      offB_r  <= `OMN_RST_BYTE;
    end
    else if (wbWrite && wb_sel_i[0])
    begin
      case (regIdx)
        `OMN_IDX_GAIN_A:   gainA_r <= wb_dat_i[7:0];
        `OMN_IDX_GAIN_B:   gainB_r <= wb_dat_i[7:0];
        `OMN_IDX_OFFSET_A: offA_r  <= wb_dat_i[7:0];
        `OMN_IDX_OFFSET_B: offB_r  <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      srcCfg_r  <= `OMN_RST_BYTE;
      idxSel_r  <= `OMN_RST_BYTE;
      thrHigh_r <= `OMN_RST_BYTE;
      thrLow_r  <= `OMN_RST_BYTE;
      period_r  <= `OMN_RST_BYTE;
      ctrl_r    <= `OMN_RST_BYTE;
    end
    else if (wbWrite && wb_sel_i[0])
    begin
      case (regIdx)
        `OMN_IDX_SRC_CFG:  srcCfg_r  <= wb_dat_i[7:0];
        `OMN_IDX_IDX_SEL:  idxSel_r  <= wb_dat_i[7:0];
        `OMN_IDX_THR_HIGH: thrHigh_r <= wb_dat_i[7:0];
        `OMN_IDX_THR_LOW:  thrLow_r  <= wb_dat_i[7:0];
        `OMN_IDX_PERIOD:   period_r  <= wb_dat_i[7:0];
        `OMN_IDX_CTRL:     ctrl_r    <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int n = 0; n < N; n++)
      begin
        step_r[n]  <= `OMN_RST_WORD;
        phase_r[n] <= `OMN_RST_HALF;
      end
    end
    else if (wbWrite && isPreset(regIdx, `OMN_IDX_STEP_BASE))
      step_r[regIdx[2:0]] <= laneMerge(step_r[regIdx[2:0]], wb_dat_i, wb_sel_i);
    else if (wbWrite && isPreset(regIdx, `OMN_IDX_PHASE_BASE))
      phase_r[regIdx[2:0]] <= 16'(laneMerge({16'h0000, phase_r[regIdx[2:0]]}, wb_dat_i,
                                            wb_sel_i));
  end

  always_comb
  begin
    readMux = `OMN_RST_WORD;
    if (isPreset(regIdx, `OMN_IDX_STEP_BASE))
      readMux = step_r[regIdx[2:0]];
    else if (isPreset(regIdx, `OMN_IDX_PHASE_BASE))
      readMux = {16'h0000, phase_r[regIdx[2:0]]};
    else
    begin
      case (regIdx)
        `OMN_IDX_GAIN_A:   readMux[7:0] = gainA_r;
        `OMN_IDX_GAIN_B:   readMux[7:0] = gainB_r;
        `OMN_IDX_OFFSET_A: readMux[7:0] = offA_r;
        `OMN_IDX_OFFSET_B: readMux[7:0] = offB_r;
        `OMN_IDX_SRC_CFG:  readMux[7:0] = srcCfg_r;
        `OMN_IDX_IDX_SEL:  readMux[7:0] = idxSel_r;
        `OMN_IDX_THR_HIGH: readMux[7:0] = thrHigh_r;
        `OMN_IDX_THR_LOW:  readMux[7:0] = thrLow_r;
        `OMN_IDX_PERIOD:   readMux[7:0] = period_r;
        `OMN_IDX_CTRL:     readMux[7:0] = ctrl_r;
        `OMN_IDX_STATUS:
        begin
          readMux[`OMN_STAT_FLAGH_BIT]            = flagHigh;
          readMux[`OMN_STAT_FLAGL_BIT]            = flagLow;
          readMux[`OMN_STAT_IDX_LSB +: 3]         = curIdx_r;
          readMux[`OMN_STAT_PD_BIT]               = powerDown;
        end
        default: readMux = `OMN_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wb_dat_o <= `OMN_RST_WORD;
    else if (wbReq && !wb_ack_o)
      wb_dat_o <= readMux;
  end

  // Preset index source and decode
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      curIdx_r <= `OMN_RST_IDX;
    else if (srcCfg_r[`OMN_SRC_BIT])
      curIdx_r <= idxSel_r[2:0];
    else
      curIdx_r <= presetIndexPins;
  end

  omn_nco_bank #(
    .N   (N),
    .AW  (32),
    .PHW (16),
    .IW  (3)
  ) uNco (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .stepPreset  (step_r),
    .phasePreset (phase_r),
    .selIdx      (curIdx_r),
    .phaseOut    (phaseSel)
  );

  omn_range_mon #(
    .SW (SW),
    .TW (8),
    .PW (3)
  ) uMon (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .run       (!powerDown),
    .sampleIn  (sampleIn),
    .thrHigh   (thrHigh_r),
    .thrLow    (thrLow_r),
    .periodExp (period_r[2:0]),
    .flagHigh  (flagHigh),
    .flagLow   (flagLow)
  );

  // Two sample stages line the data up with the registered phase
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sample_r    <= '0;
      sampleMix_r <= '0;
    end
    else
    begin
      sample_r    <= sampleIn;
      sampleMix_r <= sample_r;
    end
  end

  assign cosV  = sineAt(phaseSel + `OMN_QUARTER_TURN);
  assign sinV  = sineAt(phaseSel);
  assign sx    = $signed({~sampleMix_r[SW-1], sampleMix_r[SW-2:0]});
  // Mix down with exp(-j w n): I = x cos, Q = -x sin
  assign iProd = PW'(sx * cosV);
  assign qProd = PW'(-(sx * sinV));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      iqOut   <= '0;
      iqValid <= 1'b0;
    end
    else if (powerDown)
    begin
      iqOut   <= '0;
      iqValid <= 1'b0;
    end
    else
    begin
      iqOut.i <= {iProd[PW-1 -: 15], flagHigh};
      iqOut.q <= {qProd[PW-1 -: 15], flagLow};
      iqValid <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      analogOut     <= '0;
      powerDown     <= 1'b0;
      serialDriveEn <= 1'b0;
    end
    else
    begin
      analogOut.gain   <= {gainB_r, gainA_r};
      // Offset trim is forced neutral while calibration runs in the background
      analogOut.offset <= ctrl_r[`OMN_CTRL_BGCAL_BIT] ? `OMN_RST_HALF
                                                      : {offB_r, offA_r};
      powerDown        <= ctrl_r[`OMN_CTRL_PD_BIT];
      serialDriveEn    <= !ctrl_r[`OMN_CTRL_PD_BIT];
    end
  end

endmodule : omn_top

// ==== omn_top_asserts.sv ====
// Checker for the monitor/oscillator top: bus answer, setting outputs, power-down.
// Assumes it is bound to omn_top; it mirrors register writes seen on the bus.
`include "omn_map.svh"

module omn_top_asserts (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [13:0]          wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic                 wb_ack_o,
  input wire logic                 iqValid,
  input wire omn_pkg::omn_analog_t analogOut,
  input wire logic                 powerDown,
  input wire logic                 serialDriveEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gainSh;
  logic [15:0] offSh;
  logic [15:0] offExp;
  logic        pdSh;
  logic        calSh;
  logic        wrHit;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  assign wrHit  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign offExp = calSh ? 16'h0000 : offSh;

  // A write lands at the edge that sees ack, as in the design
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gainSh <= 16'h0000;
      offSh  <= 16'h0000;
      {calSh, pdSh} <= 2'h0;
    end
    else if (wrHit)
    begin
      case (wb_adr_i[13:2])
        `OMN_IDX_GAIN_A:   gainSh[7:0] <= wb_dat_i[7:0];
        `OMN_IDX_GAIN_B:   gainSh[15:8] <= wb_dat_i[7:0];
        `OMN_IDX_OFFSET_A: offSh[7:0] <= wb_dat_i[7:0];
        `OMN_IDX_OFFSET_B: offSh[15:8] <= wb_dat_i[7:0];
        `OMN_IDX_CTRL:     {calSh, pdSh} <= wb_dat_i[1:0];
        default:           gainSh <= gainSh;
      endcase
    end
  end

  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  ack_pulse_a: assert property (wbReq |=> ackPulse)
    else $error("bus ack is not a one-cycle answer");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("bus ack without a request");
  gain_pair_a: assert property (analogOut.gain == $past(gainSh))
    else $error("gain output differs from its two bytes");
  offset_mask_a: assert property (analogOut.offset == $past(offExp))
    else $error("offset output wrong for calibration state");
  pd_follow_a: assert property (powerDown == $past(pdSh))
    else $error("power-down output does not follow its bit");
  drive_off_a: assert property (!$past(rst) |-> serialDriveEn == !powerDown)
    else $error("output drivers enabled in power-down");
  pd_quiet_a: assert property (powerDown [*2] |-> !iqValid)
    else $error("sample words valid during power-down");
  resume_a: assert property (!powerDown [*3] |-> iqValid)
    else $error("sample words missing while powered up");
endmodule : omn_top_asserts

bind omn_top omn_top_asserts u_chk (
  .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .iqValid, .analogOut, .powerDown, .serialDriveEn
);

// ==== omn_rx_model.sv ====
// Receiver model: takes sample words, drops stale ones, gives gain advice.
// Assumes one word per sys_clk on iqOut while the drivers are enabled.
module omn_rx_model #(
  parameter int FLUSH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire omn_pkg::omn_iq_t iqOut,
  input  wire logic             iqValid,
  input  wire logic             serialDriveEn,
  output logic                  lowerGain,
  output logic                  raiseGain,
  output logic                  wordOk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flushCnt_r;
  logic [7:0] quietCnt_r;

  // Pipeline contents after power-down are meaningless until flushed
  always_ff @(posedge sys_clk)
  begin
    if (rst || !serialDriveEn)
      flushCnt_r <= 8'(FLUSH);
    else if (flushCnt_r != 8'h00)
      flushCnt_r <= flushCnt_r - 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || (wordOk && iqOut.q[0]))
      quietCnt_r <= 8'h00;
    else if (wordOk && quietCnt_r != 8'hff)
      quietCnt_r <= quietCnt_r + 8'h01;
  end

  assign wordOk    = iqValid && serialDriveEn && flushCnt_r == 8'h00;
  assign lowerGain = wordOk && iqOut.i[0];
  assign raiseGain = quietCnt_r == 8'hff;
endmodule : omn_rx_model

// ==== overrange_monitor_and_nco_select_tb.sv ====
// Self-checking bench for omn_top with the receiver model on its sample side.
// Assumes step presets stay 0 while products are checked, so phase equals preset.
`include "omn_map.svh"

module overrange_monitor_and_nco_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] s;
    logic [7:0]  th;
    logic [7:0]  tl;
    logic [2:0]  ix;
    logic        eh;
    logic        el;
  } omn_row_t;

  logic                 sys_clk;
  logic                 rst = 1'b1;
  logic                 wbCyc = 1'b0;
  logic                 wbStb = 1'b0;
  logic                 wbWe = 1'b0;
  logic [13:0]          wbAdr = 14'h0000;
  logic [31:0]          wbDat = 32'h0000_0000;
  logic [31:0]          wbDatO;
  logic                 wbAck;
  logic [11:0]          sample = 12'h800;
  logic [2:0]           pins = 3'h0;
  omn_pkg::omn_iq_t     iq;
  omn_pkg::omn_analog_t analog;
  logic                 iqValid;
  logic                 powerDown;
  logic                 driveEn;
  logic                 lowerGain;
  logic                 wordOk;
  logic [31:0]          q;
  logic [31:0]          cnt;
  int                   miscompares = 0;
  int                   comparisons = 0;
  logic [11:0]          regs [4] = '{`OMN_IDX_GAIN_A, `OMN_IDX_GAIN_B,
                                     `OMN_IDX_OFFSET_A, `OMN_IDX_OFFSET_B};
  logic [2:0]           pers [3] = '{3'h0, 3'h3, 3'h7};
  omn_row_t             rows [6] = '{
    '{12'hfff, 8'hff, 8'h40, 3'h0, 1'b1, 1'b1},
    '{12'h000, 8'hff, 8'h40, 3'h5, 1'b1, 1'b1},
    '{12'h010, 8'hff, 8'hfe, 3'h0, 1'b0, 1'b1},
    '{12'h800, 8'h01, 8'h00, 3'h5, 1'b0, 1'b1},
    '{12'ha00, 8'he4, 8'h40, 3'h0, 1'b0, 1'b1},
    '{12'h9ff, 8'he4, 8'h40, 3'h5, 1'b0, 1'b0}};

  omn_top dut (
    .sys_clk, .rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .sampleIn(sample), .presetIndexPins(pins), .iqOut(iq),
    .iqValid, .analogOut(analog), .powerDown, .serialDriveEn(driveEn));

  omn_rx_model rx (
    .sys_clk, .rst, .iqOut(iq), .iqValid, .serialDriveEn(driveEn),
    .lowerGain, .raiseGain(), .wordOk);

  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wbX(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= {a, 2'b00};
    wbDat <= d;
    @(posedge sys_clk);
    while (wbAck !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50)
      miscompares++;
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
  endtask : wbX

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] j;
    wbX(1'b1, a, d, j);
  endtask : wr

  function automatic omn_pkg::omn_iq_t expIq(input omn_row_t r);
    logic signed [20:0] p;
    logic signed [20:0] n;
    omn_pkg::omn_iq_t   e;
    p = $signed({~r.s[11], r.s[10:0]}) * 21'sd255;
    n = -p;
    e.i = (r.ix == 3'h5) ? {15'h0000, r.eh} : {p[20:6], r.eh};
    e.q = (r.ix == 3'h5) ? {n[20:6], r.el} : {15'h0000, r.el};
    return e;
  endfunction : expIq

  task automatic doRow(input omn_row_t r, input logic [2:0] p);
    wr(`OMN_IDX_THR_HIGH, {24'h0, r.th});
    wr(`OMN_IDX_THR_LOW, {24'h0, r.tl});
    sample <= r.s;
    pins   <= p;
    repeat (8) @(posedge sys_clk);
    chk("iqOut", expIq(r), iq);
    chk("lowerGain", {31'h0, r.eh}, {31'h0, lowerGain});
  endtask : doRow

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Sized from the whole sequence, about sixteen hundred cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (regs[k])
    begin
      wbX(1'b0, regs[k], 32'h0, q);
      chk("regReset", 32'h0, q);
      wr(regs[k], 32'h12 + 32'h22 * k);
      wbX(1'b0, regs[k], 32'h0, q);
      chk("regBack", 32'h12 + 32'h22 * k, q);
    end
    wr(12'h3ff, 32'hff);
    wbX(1'b0, 12'h3ff, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("analogOut", 32'h3412_7856, analog);
    wr(`OMN_IDX_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk("analogOut", 32'h3412_0000, analog);
    wr(`OMN_IDX_CTRL, 32'h0);
    wr(`OMN_IDX_PHASE_BASE + 12'h005, 32'h4000);
    foreach (rows[k])
      doRow(rows[k], rows[k].ix);
    wr(`OMN_IDX_SRC_CFG, 32'h1);
    wr(`OMN_IDX_IDX_SEL, 32'h5);
    doRow(rows[1], 3'h2);
    wr(`OMN_IDX_IDX_SEL, 32'h0);
    doRow(rows[2], 3'h5);
    wr(`OMN_IDX_THR_HIGH, 32'hff);
    foreach (pers[k])
    begin
      wr(`OMN_IDX_PERIOD, {29'h0, pers[k]});
      sample <= 12'h800;
      repeat (140) @(posedge sys_clk);
      sample <= 12'hfff;
      @(posedge sys_clk);
      sample <= 12'h800;
      cnt = 32'h0;
      repeat (300)
      begin
        @(posedge sys_clk);
        cnt += {31'h0, iq.i[0]};
      end
      chk("flagSpan", 32'h1 << pers[k], cnt);
    end
    // Step change mid-run; the power cycle below re-establishes the link
    wr(`OMN_IDX_STEP_BASE + 12'h007, 32'h0100_0000);
    wbX(1'b0, `OMN_IDX_STEP_BASE + 12'h007, 32'h0, q);
    chk("stepBack", 32'h0100_0000, q);
    wr(`OMN_IDX_CTRL, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk("powerDown", 32'h1, {31'h0, powerDown});
    chk("driveEn", 32'h0, {31'h0, driveEn});
    chk("iqValid", 32'h0, {31'h0, iqValid});
    chk("iqOut", 32'h0, iq);
    wbX(1'b0, `OMN_IDX_STATUS, 32'h0, q);
    chk("status", 32'h20, q);
    wr(`OMN_IDX_CTRL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("wordOk", 32'h0, {31'h0, wordOk});
    repeat (16) @(posedge sys_clk);
    chk("wordOk", 32'h1, {31'h0, wordOk});
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("analogOut", 32'h0, analog);
    chk("iqValid", 32'h0, {31'h0, iqValid});
    chk("driveEn", 32'h0, {31'h0, driveEn});
    rst <= 1'b0;
    @(posedge sys_clk);
    wbX(1'b0, `OMN_IDX_GAIN_A, 32'h0, q);
    chk("regReset", 32'h0, q);
    wrap_up();
  end
endmodule : overrange_monitor_and_nco_select_tb
